// File: design/stack_addr_gen.sv
/*
  Stack pointer, stack limit check and program space address generation, with a
  classic Wishbone register slave. Assumes the execute stage drives one request
  per cycle and that memory returns program words on prog_rvalid_i.
*/
// Behaviour
// - Stack pointer addresses next free word, grows up
// - Pop predecrements, push postincrements the pointer
// - Call push zero-extends counter upper part
// - Exception push joins status byte to counter
// - Limit bit zero forced low, no reset
// - Stack pointer addresses compared against limit
// - Push at limit passes, next one traps
// - Address below 0800h raises underflow trap
// - Table and window addresses from 16-bit data plus page
// - Table address is page joined to address
// - Each table page selects 32K words
// - Table page top bit selects configuration space
// - Table access unaligned, reads allowed in configuration
// - Table access reaches every program word byte
// - Window address is page plus low fifteen bits
// - Each visibility page selects 16K words
// - Program bit 15 from visibility page bit 0
// - Window access forced to user space
// - Window read-only, returns low program word
// - Fetch address from counter, bit zero clear
// - Window only when visibility enable set
// - Window read stalls instruction one cycle
// - Table writes to configuration space refused
module stack_addr_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire addr_gen_pkg::stack_req_t stack_req_i,
  input wire logic [22:0] pc_i,
  input wire logic [7:0] status_low_byte_i,
  input wire addr_gen_pkg::prog_req_t prog_req_i,
  input wire logic prog_rvalid_i,
  input wire logic [23:0] prog_rdata_i,
  output logic [15:0] stack_addr_o,
  output logic [15:0] stack_wdata_o,
  output logic stack_we_o,
  output logic stack_re_o,
  output logic stack_trap_o,
  output addr_gen_pkg::prog_addr_t prog_addr_o,
  output logic refused_o,
  output logic stall_o,
  output logic [15:0] data_rdata_o,
  output logic data_rvalid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte lane merge for 16-bit registers
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  logic bus_req;
  logic bus_wr;
  logic next_ack;
  logic [31:0] next_dat;
  logic [15:0] sp;
  logic [15:1] limit_hi;
  logic [15:0] limit;
  logic [7:0] table_page_reg;
  logic [7:0] visibility_page_reg;
  logic [15:0] core_control_reg;
  logic [1:0] stack_status;

  assign limit = {limit_hi, 1'b0};
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & wb_ack_o;

  always_comb begin
    next_ack = bus_req & ~wb_ack_o;
    next_dat = 32'h0000_0000;
    if (bus_req & ~wb_ack_o & ~wb_we_i) begin
      unique case (wb_adr_i)
        addr_gen_pkg::OFS_STACK_POINTER: next_dat = {16'h0000, sp};
        addr_gen_pkg::OFS_STACK_LIMIT: next_dat = {16'h0000, limit};
        addr_gen_pkg::OFS_TABLE_PAGE: next_dat = {24'h00_0000, table_page_reg};
        addr_gen_pkg::OFS_VIS_PAGE: next_dat = {24'h00_0000, visibility_page_reg};
        addr_gen_pkg::OFS_CORE_CONTROL: next_dat = {16'h0000, core_control_reg};
        addr_gen_pkg::OFS_STACK_STATUS: next_dat = {30'h0000_0000, stack_status};
        default: next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [7:0] next_table_page;
  logic [7:0] next_vis_page;
  logic [15:0] next_core_control;
  logic [15:1] next_limit_hi;
  logic [15:0] lim_merge;

  always_comb begin
    next_table_page = table_page_reg;
    next_vis_page = visibility_page_reg;
    next_core_control = core_control_reg;
    lim_merge = lane_merge(limit, wb_dat_i, wb_sel_i);
    next_limit_hi = limit_hi;
    if (bus_wr) begin
      unique case (wb_adr_i)
        addr_gen_pkg::OFS_TABLE_PAGE: next_table_page = wb_sel_i[0] ? wb_dat_i[7:0] : table_page_reg;
        addr_gen_pkg::OFS_VIS_PAGE: next_vis_page = wb_sel_i[0] ? wb_dat_i[7:0] : visibility_page_reg;
        addr_gen_pkg::OFS_CORE_CONTROL: next_core_control = lane_merge(core_control_reg, wb_dat_i, wb_sel_i);
        addr_gen_pkg::OFS_STACK_LIMIT: next_limit_hi = lim_merge[15:1];
        default: next_limit_hi = limit_hi;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      table_page_reg <= addr_gen_pkg::PAGE_RESET;
      visibility_page_reg <= addr_gen_pkg::PAGE_RESET;
      core_control_reg <= addr_gen_pkg::CTRL_RESET;
    end else begin
      table_page_reg <= next_table_page;
      visibility_page_reg <= next_vis_page;
      core_control_reg <= next_core_control;
    end
  end

  // Limit keeps its value across reset
  always_ff @(posedge clk_i) begin
    limit_hi <= next_limit_hi;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer and limit check
  logic [15:0] next_sp;
  logic [15:0] chk_addr;
  logic chk_valid;
  logic ovf;
  logic unf;
  logic [15:0] next_stack_addr;
  logic [15:0] next_stack_wdata;
  logic [1:0] next_status;
  logic [15:0] sp_merge;

  always_comb begin
    sp_merge = lane_merge(sp, wb_dat_i, wb_sel_i);
    next_sp = sp;
    chk_valid = stack_req_i.push | stack_req_i.pop | stack_req_i.sp_ea;
    if (stack_req_i.push) begin
      chk_addr = sp;
      next_sp = sp + addr_gen_pkg::STACK_STEP;
    end else if (stack_req_i.pop) begin
      chk_addr = sp - addr_gen_pkg::STACK_STEP;
      next_sp = chk_addr;
    end else begin
      chk_addr = stack_req_i.ea;
      if (bus_wr && wb_adr_i == addr_gen_pkg::OFS_STACK_POINTER) begin
        next_sp = {sp_merge[15:1], 1'b0};
      end
    end
    ovf = chk_valid & (chk_addr > limit);
    unf = chk_valid & (chk_addr < addr_gen_pkg::SFR_FLOOR);
    next_stack_addr = chk_valid ? chk_addr : stack_addr_o;
    unique case (stack_req_i.kind)
      addr_gen_pkg::PUSH_DATA: next_stack_wdata = stack_req_i.wdata;
      addr_gen_pkg::PUSH_PC_LOW: next_stack_wdata = pc_i[15:0];
      addr_gen_pkg::PUSH_PC_CALL: next_stack_wdata = {9'h000, pc_i[22:16]};
      addr_gen_pkg::PUSH_PC_EXC: next_stack_wdata = {status_low_byte_i, 1'b0, pc_i[22:16]};
    endcase
    next_status = stack_status;
    if (bus_wr && wb_adr_i == addr_gen_pkg::OFS_STACK_STATUS && wb_sel_i[0]) begin
      next_status = stack_status & ~wb_dat_i[1:0];
    end
    next_status[addr_gen_pkg::STAT_OVF_BIT] = next_status[addr_gen_pkg::STAT_OVF_BIT] | ovf;
    next_status[addr_gen_pkg::STAT_UNF_BIT] = next_status[addr_gen_pkg::STAT_UNF_BIT] | unf;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp <= addr_gen_pkg::SP_RESET;
      stack_addr_o <= addr_gen_pkg::SP_RESET;
      stack_wdata_o <= 16'h0000;
      stack_we_o <= 1'b0;
      stack_re_o <= 1'b0;
      stack_trap_o <= 1'b0;
      stack_status <= addr_gen_pkg::STAT_RESET;
    end else begin
      sp <= next_sp;
      stack_addr_o <= next_stack_addr;
      stack_wdata_o <= stack_req_i.push ? next_stack_wdata : stack_wdata_o;
      stack_we_o <= stack_req_i.push;
      stack_re_o <= ~stack_req_i.push & stack_req_i.pop;
      stack_trap_o <= ovf | unf;
      stack_status <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program space address generation
  addr_gen_pkg::prog_addr_t next_prog;
  logic next_refused;
  logic next_stall;
  logic vis_hit;
  addr_gen_pkg::prog_kind_t rd_kind;
  addr_gen_pkg::prog_kind_t next_rd_kind;

  always_comb begin
    next_prog = '0;
    next_refused = 1'b0;
    next_stall = 1'b0;
    next_rd_kind = rd_kind;
    vis_hit = prog_req_i.ea[addr_gen_pkg::EA_MSB] & core_control_reg[addr_gen_pkg::VIS_EN_BIT];
    unique case (prog_req_i.kind)
      addr_gen_pkg::PROG_IDLE: next_prog = '0;
      addr_gen_pkg::PROG_FETCH: begin
        next_prog.valid = 1'b1;
        next_prog.addr = {1'b0, pc_i[22:1], 1'b0};
      end
      addr_gen_pkg::PROG_TBL_RD_LO, addr_gen_pkg::PROG_TBL_RD_HI: begin
        next_prog.valid = 1'b1;
        next_prog.config_space = table_page_reg[addr_gen_pkg::CFG_PAGE_BIT];
        next_prog.addr = {table_page_reg, prog_req_i.ea};
        next_rd_kind = prog_req_i.kind;
      end
      addr_gen_pkg::PROG_TBL_WR: begin
        if (table_page_reg[addr_gen_pkg::CFG_PAGE_BIT]) begin
          next_refused = 1'b1;
        end else begin
          next_prog.valid = 1'b1;
          next_prog.write = 1'b1;
          next_prog.addr = {table_page_reg, prog_req_i.ea};
        end
      end
      addr_gen_pkg::PROG_DATA_RD: begin
        if (vis_hit) begin
          next_prog.valid = 1'b1;
          next_prog.addr = {1'b0, visibility_page_reg, prog_req_i.ea[14:0]};
          next_stall = 1'b1;
          next_rd_kind = prog_req_i.kind;
        end
      end
      addr_gen_pkg::PROG_DATA_WR: next_refused = vis_hit;
      default: next_prog = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_addr_o <= '0;
      refused_o <= 1'b0;
      stall_o <= 1'b0;
      rd_kind <= addr_gen_pkg::PROG_IDLE;
    end else begin
      prog_addr_o <= next_prog;
      refused_o <= next_refused;
      stall_o <= next_stall;
      rd_kind <= next_rd_kind;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data return
  logic [15:0] next_rdata;

  always_comb begin
    if (rd_kind == addr_gen_pkg::PROG_TBL_RD_HI) begin
      next_rdata = {8'h00, prog_rdata_i[23:16]};
    end else begin
      next_rdata = prog_rdata_i[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_rdata_o <= 16'h0000;
      data_rvalid_o <= 1'b0;
    end else begin
      data_rdata_o <= prog_rvalid_i ? next_rdata : data_rdata_o;
      data_rvalid_o <= prog_rvalid_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_sp_aligned;
    @(posedge clk_i) disable iff (rst_i) sp[0] == 1'b0;
  endproperty
  a_sp_aligned: assert property (p_sp_aligned) else $error("stack pointer odd");

  property p_push_inc;
    @(posedge clk_i) disable iff (rst_i)
      stack_req_i.push |=> sp == $past(sp) + 16'h0002 && stack_addr_o == $past(sp) && stack_we_o;
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push did not post-increment");

  property p_pop_dec;
    @(posedge clk_i) disable iff (rst_i)
      (stack_req_i.pop && !stack_req_i.push) |=> sp == $past(sp) - 16'h0002 && stack_addr_o == sp && stack_re_o;
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("pop did not pre-decrement");

  property p_call_zero;
    @(posedge clk_i) disable iff (rst_i)
      (stack_req_i.push && stack_req_i.kind == addr_gen_pkg::PUSH_PC_CALL) |=>
        stack_wdata_o == {9'h000, $past(pc_i[22:16])};
  endproperty
  a_call_zero: assert property (p_call_zero) else $error("call push upper bits not clear");

  property p_exc_status;
    @(posedge clk_i) disable iff (rst_i)
      (stack_req_i.push && stack_req_i.kind == addr_gen_pkg::PUSH_PC_EXC) |=>
        stack_wdata_o[15:8] == $past(status_low_byte_i) && stack_wdata_o[6:0] == $past(pc_i[22:16]);
  endproperty
  a_exc_status: assert property (p_exc_status) else $error("exception push missing status byte");

  property p_underflow;
    @(posedge clk_i) disable iff (rst_i)
      (stack_req_i.pop && !stack_req_i.push && sp < 16'h0802 && sp > 16'h0001) |=>
        stack_trap_o && stack_status[addr_gen_pkg::STAT_UNF_BIT];
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow not trapped");

  property p_at_limit;
    @(posedge clk_i) disable iff (rst_i)
      (stack_req_i.push && sp == limit && sp >= 16'h0800) |=> !stack_trap_o;
  endproperty
  a_at_limit: assert property (p_at_limit) else $error("push at limit trapped");

  property p_over_limit;
    @(posedge clk_i) disable iff (rst_i)
      (stack_req_i.push && sp > limit) |=> stack_trap_o;
  endproperty
  a_over_limit: assert property (p_over_limit) else $error("push past limit not trapped");

  property p_table_addr;
    @(posedge clk_i) disable iff (rst_i)
      (prog_req_i.kind == addr_gen_pkg::PROG_TBL_RD_LO) |=>
        prog_addr_o.valid && prog_addr_o.addr == {$past(table_page_reg), $past(prog_req_i.ea)} &&
        prog_addr_o.config_space == $past(table_page_reg[7]);
  endproperty
  a_table_addr: assert property (p_table_addr) else $error("table address wrong");

  property p_vis_addr;
    @(posedge clk_i) disable iff (rst_i)
      (prog_req_i.kind == addr_gen_pkg::PROG_DATA_RD && vis_hit) |=>
        prog_addr_o.addr[23] == 1'b0 && prog_addr_o.addr[22:15] == $past(visibility_page_reg) &&
        !prog_addr_o.config_space && stall_o ##1
        (!stall_o || $past(prog_req_i.kind == addr_gen_pkg::PROG_DATA_RD && vis_hit));
  endproperty
  a_vis_addr: assert property (p_vis_addr) else $error("visibility address or stall wrong");

  property p_vis_off;
    @(posedge clk_i) disable iff (rst_i)
      (prog_req_i.kind == addr_gen_pkg::PROG_DATA_RD && !core_control_reg[2]) |=> !prog_addr_o.valid && !stall_o;
  endproperty
  a_vis_off: assert property (p_vis_off) else $error("remap while visibility disabled");

  property p_fetch;
    @(posedge clk_i) disable iff (rst_i)
      (prog_req_i.kind == addr_gen_pkg::PROG_FETCH) |=> prog_addr_o.addr == {1'b0, $past(pc_i[22:1]), 1'b0};
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrong");

  property p_cfg_write;
    @(posedge clk_i) disable iff (rst_i)
      (prog_req_i.kind == addr_gen_pkg::PROG_TBL_WR && table_page_reg[7]) |=> refused_o && !prog_addr_o.valid;
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("configuration write not refused");

  property p_page_reset;
    @(posedge clk_i) rst_i |=> table_page_reg == 8'h00 && visibility_page_reg == 8'h00;
  endproperty
  a_page_reset: assert property (p_page_reset) else $error("page registers not cleared");

endmodule // stack_addr_gen

// File: design/addr_gen_pkg.sv
/*
  Shared constants and carrier types for the stack check and program address generator.
  Assumes a single core clock and a synchronous active-high reset in the user.
*/
package addr_gen_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets, byte addresses on the bus
  localparam logic [7:0] OFS_STACK_POINTER = 8'h00;
  localparam logic [7:0] OFS_STACK_LIMIT = 8'h04;
  localparam logic [7:0] OFS_TABLE_PAGE = 8'h08;
  localparam logic [7:0] OFS_VIS_PAGE = 8'h0c;
  localparam logic [7:0] OFS_CORE_CONTROL = 8'h10;
  localparam logic [7:0] OFS_STACK_STATUS = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and values
  localparam int VIS_EN_BIT = 2;
  localparam int CFG_PAGE_BIT = 7;
  localparam int EA_MSB = 15;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_UNF_BIT = 1;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] SFR_FLOOR = 16'h0800;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [1:0] STAT_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Stack requests from the execute stage
  typedef enum logic [1:0] {PUSH_DATA, PUSH_PC_LOW, PUSH_PC_CALL, PUSH_PC_EXC} push_kind_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic sp_ea;
    push_kind_t kind;
    logic [15:0] ea;
    logic [15:0] wdata;
  } stack_req_t;

  ////////////////////////////////////////////////////////////////////////////
  // Program space requests and generated addresses
  typedef enum logic [2:0] {
    PROG_IDLE, PROG_FETCH, PROG_TBL_RD_LO, PROG_TBL_RD_HI, PROG_TBL_WR, PROG_DATA_RD, PROG_DATA_WR
  } prog_kind_t;

  typedef struct packed {
    prog_kind_t kind;
    logic [15:0] ea;
  } prog_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic config_space;
    logic [23:0] addr;
  } prog_addr_t;

endpackage

// File: testbench/prog_mem_model.sv
/*
  Program memory model on the far side of the address generator.
  Assumes one core clock; answers each program read after one to three cycles.
*/
module prog_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire addr_gen_pkg::prog_addr_t prog_addr_i,
  output logic rvalid_o,
  output logic [23:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [23:0] addr = 24'h0;
  int wait_n = 0;

  initial begin
    rvalid_o = 1'b0;
    rdata_o = 24'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answer, data bus toggles while idle
  always @(posedge clk_i) begin
    rvalid_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i) begin
      wait_n <= 0;
    end else if (prog_addr_i.valid && !prog_addr_i.write) begin
      addr <= prog_addr_i.addr;
      wait_n <= 1 + $urandom_range(2);
    end else if (wait_n == 1) begin
      rvalid_o <= 1'b1;
      rdata_o <= {addr[7:0] ^ addr[23:16], addr[15:0] ^ 16'h3c5a};
      wait_n <= 0;
    end else if (wait_n > 1) begin
      wait_n <= wait_n - 1;
    end
  end
endmodule // prog_mem_model

// File: testbench/tb.sv
/*
  Self-checking bench for the stack check and program address generator.
  Assumes the design package and a program memory model on the far side.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  addr_gen_pkg::stack_req_t stack_req_i = '0;
  logic [22:0] pc_i = 23'h0;
  logic [7:0] status_low_byte_i = 8'h00;
  addr_gen_pkg::prog_req_t prog_req_i = '0;
  logic prog_rvalid_i;
  logic [23:0] prog_rdata_i;
  logic [15:0] stack_addr_o, stack_wdata_o, data_rdata_o;
  logic stack_we_o, stack_re_o, stack_trap_o, refused_o, stall_o, data_rvalid_o;
  addr_gen_pkg::prog_addr_t prog_addr_o;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] sp = 16'h0800;
  logic [15:0] lim = 16'h0;
  logic [7:0] tpg = 8'h0;
  logic [7:0] vpg = 8'h0;
  logic en = 1'b0;
  logic [1:0] stat = 2'h0;
  logic e_we = 1'b0, e_re = 1'b0, e_trap = 1'b0, e_ref = 1'b0, e_stall = 1'b0;
  logic [15:0] e_addr = 16'h0800;
  logic [15:0] e_wd = 16'h0;
  addr_gen_pkg::prog_addr_t e_pa = '0;
  logic [15:0] rq[$];
  logic [31:0] q;
  logic last_hi = 1'b0;

  stack_addr_gen u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .stack_req_i(stack_req_i), .pc_i(pc_i), .status_low_byte_i(status_low_byte_i),
    .prog_req_i(prog_req_i), .prog_rvalid_i(prog_rvalid_i), .prog_rdata_i(prog_rdata_i),
    .stack_addr_o(stack_addr_o), .stack_wdata_o(stack_wdata_o), .stack_we_o(stack_we_o),
    .stack_re_o(stack_re_o), .stack_trap_o(stack_trap_o), .prog_addr_o(prog_addr_o), .refused_o(refused_o),
    .stall_o(stall_o), .data_rdata_o(data_rdata_o), .data_rvalid_o(data_rvalid_o));

  prog_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .prog_addr_i(prog_addr_o), .rvalid_o(prog_rvalid_i),
    .rdata_o(prog_rdata_i));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking and closing
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      summarize();
    end
  end

  always @(negedge clk_i) begin
    if (!rst_i && data_rvalid_o === 1'b1) begin
      if (rq.size() == 0) check("extra return", 1, 0);
      else check("return data", data_rdata_o, rq.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone classic master
  task automatic wb(logic we, logic [7:0] adr, logic [31:0] d, output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    check("ack", wb_ack_o, 1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd_chk(logic [7:0] adr, logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, adr, 32'h0, r);
    check("register", r, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One request per cycle, previous result checked against the model
  task automatic issue(addr_gen_pkg::stack_req_t s, addr_gen_pkg::prog_req_t p);
    logic [15:0] a;
    logic [22:0] pc;
    logic [7:0] sl;
    logic [23:0] w;
    pc = 23'($urandom);
    sl = 8'($urandom);
    a = s.ea;
    @(posedge clk_i);
    stack_req_i <= s;
    prog_req_i <= p;
    pc_i <= pc;
    status_low_byte_i <= sl;
    @(negedge clk_i);
    check("push strobe", stack_we_o, e_we);
    check("pop strobe", stack_re_o, e_re);
    check("trap", stack_trap_o, e_trap);
    check("stack addr", stack_addr_o, e_addr);
    check("push word", stack_wdata_o, e_wd);
    check("prog addr", prog_addr_o, e_pa);
    check("refused", refused_o, e_ref);
    check("stall", stall_o, e_stall);
    e_we = s.push;
    e_re = s.pop & ~s.push;
    e_trap = 1'b0;
    if (s.push) begin
      a = sp;
      sp = sp + 16'h2;
      case (s.kind)
        addr_gen_pkg::PUSH_DATA: e_wd = s.wdata;
        addr_gen_pkg::PUSH_PC_LOW: e_wd = pc[15:0];
        addr_gen_pkg::PUSH_PC_CALL: e_wd = {9'h0, pc[22:16]};
        default: e_wd = {sl, 1'b0, pc[22:16]};
      endcase
    end else if (s.pop) begin
      sp = sp - 16'h2;
      a = sp;
    end
    if (s.push || s.pop || s.sp_ea) begin
      e_addr = a;
      e_trap = (a > lim) || (a < 16'h0800);
      stat = stat | {a < 16'h0800, a > lim};
    end
    e_pa = '0;
    e_ref = 1'b0;
    e_stall = 1'b0;
    case (p.kind)
      addr_gen_pkg::PROG_FETCH: e_pa = {3'b100, 1'b0, pc[22:1], 1'b0};
      addr_gen_pkg::PROG_TBL_RD_LO, addr_gen_pkg::PROG_TBL_RD_HI: e_pa = {2'b10, tpg[7], tpg, p.ea};
      addr_gen_pkg::PROG_TBL_WR: if (tpg[7]) e_ref = 1'b1; else e_pa = {3'b110, tpg, p.ea};
      addr_gen_pkg::PROG_DATA_RD: if (p.ea[15] && en) begin
        e_pa = {3'b100, 1'b0, vpg, p.ea[14:0]};
        e_stall = 1'b1;
      end
      addr_gen_pkg::PROG_DATA_WR: e_ref = p.ea[15] && en;
      default: ;
    endcase
    w = {e_pa.addr[7:0] ^ e_pa.addr[23:16], e_pa.addr[15:0] ^ 16'h3c5a};
    if (e_pa.valid && !e_pa.write) begin
      if (p.kind != addr_gen_pkg::PROG_FETCH) begin
        last_hi = p.kind == addr_gen_pkg::PROG_TBL_RD_HI;
      end
      rq.push_back(last_hi ? {8'h0, w[23:16]} : w[15:0]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    addr_gen_pkg::stack_req_t sr;
    addr_gen_pkg::prog_req_t pr;
    q = $urandom(17);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(addr_gen_pkg::OFS_STACK_POINTER, 32'h0800);
    rd_chk(addr_gen_pkg::OFS_TABLE_PAGE, 32'h0);
    rd_chk(addr_gen_pkg::OFS_VIS_PAGE, 32'h0);
    rd_chk(addr_gen_pkg::OFS_CORE_CONTROL, 32'h0);
    wb(1'b1, 8'h18, 32'hffff, q);
    rd_chk(8'h18, 32'h0);
    wb(1'b1, addr_gen_pkg::OFS_STACK_LIMIT, 32'h0805, q);
    lim = 16'h0804;
    rd_chk(addr_gen_pkg::OFS_STACK_LIMIT, 32'h0804);
    for (int i = 0; i < 19; i++) begin
      sr = '{i < 5, i >= 4 && i < 11, i >= 11, addr_gen_pkg::push_kind_t'(i % 4), 16'(16'h07fc + 2 * (i - 11)),
        16'($urandom)};
      issue(sr, '0);
    end
    issue('0, '0);
    rd_chk(addr_gen_pkg::OFS_STACK_POINTER, 32'(sp));
    rd_chk(addr_gen_pkg::OFS_STACK_STATUS, 32'(stat));
    wb(1'b1, addr_gen_pkg::OFS_STACK_STATUS, 32'h3, q);
    rd_chk(addr_gen_pkg::OFS_STACK_STATUS, 32'h0);
    wb(1'b1, addr_gen_pkg::OFS_STACK_POINTER, 32'h0a13, q);
    sp = 16'h0a12;
    rd_chk(addr_gen_pkg::OFS_STACK_POINTER, 32'h0a12);
    for (int c = 0; c < 4; c++) begin
      tpg = {c[0], 7'($urandom)};
      vpg = 8'($urandom);
      en = c[1];
      wb(1'b1, addr_gen_pkg::OFS_TABLE_PAGE, 32'(tpg), q);
      wb(1'b1, addr_gen_pkg::OFS_VIS_PAGE, 32'(vpg), q);
      wb(1'b1, addr_gen_pkg::OFS_CORE_CONTROL, 32'(en) << 2, q);
      rd_chk(addr_gen_pkg::OFS_TABLE_PAGE, 32'(tpg));
      for (int j = 0; j < 14; j++) begin
        pr = '{addr_gen_pkg::prog_kind_t'(3'(1 + j % 6)), {j[0] ^ j[1], 15'($urandom)}};
        issue('0, pr);
        if (pr.kind inside {addr_gen_pkg::PROG_FETCH, addr_gen_pkg::PROG_TBL_RD_LO, addr_gen_pkg::PROG_TBL_RD_HI,
          addr_gen_pkg::PROG_DATA_RD})
          repeat (5) issue('0, '0);
      end
      issue('0, '0);
    end
    repeat (6) issue('0, '0);
    check("pending returns", rq.size(), 0);
    summarize();
  end
endmodule // tb
